// File: scq_pkg.sv
// Shared constants and types for the startup clock quality sequencer.
package scq_pkg;

    // System (self) clock rate.
    localparam int CLK_HZ = 10_000_000;

    // Quality check timeout lies between 0.45 s and 2.5 s; the upper bound is used.
    localparam real QC_TIMEOUT_S = 2.5;
    localparam int QC_TIMEOUT_CYC = int'($floor(QC_TIMEOUT_S * CLK_HZ));
    // Valid oscillator edges that declare the oscillation good.
    localparam int QC_EDGES = 4096;

    // Clock monitor threshold lies between 50 kHz and 200 kHz; 100 kHz is used.
    localparam int MON_FAIL_KHZ = 100;
    localparam int MON_FAIL_CYC = CLK_HZ / (MON_FAIL_KHZ * 1000);

    // External reset pin must stay low for this many oscillator periods.
    localparam int MIN_RST_OSC = 2;
    // Wait recovery startup time, in bus cycles.
    localparam int WRS_CYC = 14;
    // Regulator recovery after pseudo stop.
    localparam int VUP_US = 10;
    localparam int VUP_CYC = VUP_US * (CLK_HZ / 1_000_000);

    // Register byte offsets.
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] FLAG_OFS = 8'h08;

    // CTRL fields.
    localparam int CTRL_MODE_LSB = 0;
    // STATUS fields.
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_SELF_BIT = 4;
    localparam int STAT_MON_BIT = 5;
    localparam int STAT_LOWBIAS_BIT = 6;
    localparam int STAT_RUN_BIT = 7;
    localparam int STAT_OSCOK_BIT = 8;
    // FLAG fields, write one to clear.
    localparam int FLAG_POR_BIT = 0;
    localparam int FLAG_LVR_BIT = 1;
    localparam int FLAG_EXT_BIT = 2;
    localparam int FLAG_MON_BIT = 3;
    localparam logic [3:0] FLAG_RESET = 4'h1;

    typedef enum logic [1:0] {
        MODE_NONE = 2'b00,
        MODE_WAIT = 2'b01,
        MODE_PSTOP = 2'b10,
        MODE_STOP = 2'b11
    } scq_mode_t;

    typedef enum logic [3:0] {
        ST_RESET = 4'b0000,
        ST_CHECK = 4'b0001,
        ST_RUN = 4'b0010,
        ST_WAIT = 4'b0011,
        ST_PSTOP = 4'b0100,
        ST_VUP = 4'b0101,
        ST_WRS = 4'b0110,
        ST_STOP = 4'b0111
    } scq_state_t;

endpackage

// File: scq_qc_if.sv
// Link between the sequencer core and its oscillator quality checker.
`timescale 1ns/10ps
interface scq_qc_if;
    logic start;
    logic mon_en;
    logic busy;
    logic pass;
    logic tmo;
    logic mon_fail;
    logic osc_edge;

    modport ctl (output start, output mon_en, input busy, input pass, input tmo,
        input mon_fail, input osc_edge);
    modport chk (input start, input mon_en, output busy, output pass, output tmo,
        output mon_fail, output osc_edge);
endinterface

// File: scq_qual_chk.sv
// Oscillator quality checker and clock monitor running on the self clock.
`timescale 1ns/10ps
module scq_qual_chk #(
    parameter int TIMEOUT_CYC = scq_pkg::QC_TIMEOUT_CYC,
    parameter int EDGES = scq_pkg::QC_EDGES,
    parameter int MON_CYC = scq_pkg::MON_FAIL_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Oscillator pin
    input wire logic osc_in,
    // Core link
    scq_qc_if.chk qc
);

    localparam int TW = $clog2(TIMEOUT_CYC + 1);
    localparam int EW = $clog2(EDGES + 1);
    localparam int MW = $clog2(MON_CYC + 1);

    generate
        if (TIMEOUT_CYC < 2 || EDGES < 2 || MON_CYC < 2)
        begin : g_bad
            $error("scq_qual_chk: counts must be at least 2");
        end
    endgenerate

    logic osc_s1_r, osc_s2_r, osc_s3_r;
    logic busy_r, pass_r, tmo_r, mon_fail_r;
    logic [TW-1:0] tcnt_r;
    logic [EW-1:0] ecnt_r;
    logic [MW-1:0] mcnt_r;

    wire edge_seen = osc_s2_r & ~osc_s3_r;
    wire edges_done = edge_seen && (ecnt_r == EW'(EDGES - 1));
    wire time_done = (tcnt_r == TW'(TIMEOUT_CYC - 1));
    wire mon_done = (mcnt_r == MW'(MON_CYC));

    // Only the second and third stages are read; the pin is asynchronous to clk.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            osc_s1_r <= 1'b0;
            osc_s2_r <= 1'b0;
            osc_s3_r <= 1'b0;
        end
        else
        begin
            osc_s1_r <= osc_in;
            osc_s2_r <= osc_s1_r;
            osc_s3_r <= osc_s2_r;
        end
    end

    // Edges of the oscillator race the self clock timeout counter.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_r <= 1'b0;
            pass_r <= 1'b0;
            tmo_r <= 1'b0;
            tcnt_r <= '0;
            ecnt_r <= '0;
        end
        else
        begin
            pass_r <= busy_r && !qc.start && edges_done;
            tmo_r <= busy_r && !qc.start && !edges_done && time_done;
            if (qc.start)
                busy_r <= 1'b1;
            else if (edges_done || time_done)
                busy_r <= 1'b0;
            tcnt_r <= (qc.start || !busy_r) ? '0 : TW'(tcnt_r + 1'b1);
            if (qc.start || !busy_r)
                ecnt_r <= '0;
            else if (edge_seen)
                ecnt_r <= EW'(ecnt_r + 1'b1);
        end
    end

    // A missing edge for longer than the threshold period means a slow or dead oscillator.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mcnt_r <= '0;
            mon_fail_r <= 1'b0;
        end
        else
        begin
            if (!qc.mon_en || edge_seen)
                mcnt_r <= '0;
            else if (!mon_done)
                mcnt_r <= MW'(mcnt_r + 1'b1);
            mon_fail_r <= qc.mon_en && mon_done;
        end
    end

    assign qc.busy = busy_r;
    assign qc.pass = pass_r;
    assign qc.tmo = tmo_r;
    assign qc.mon_fail = mon_fail_r;
    assign qc.osc_edge = edge_seen;

endmodule

// File: scq_top.sv
// Startup and low-power recovery sequencer with oscillator quality check and APB registers.
// Summary of operation
// - Power-on release starts oscillator and quality check.
// - Low-voltage reset release also starts quality check.
// - No oscillation before timeout selects self clock.
// - Check on power-on, stop exit, oscillator failure.
// - Reset pin low two oscillator periods resets.
// - External reset with running oscillator skips quality check.
// - External interrupt wakes from full stop.
// - Stop wake-up runs check before clock release.
// - Wait and pseudo stop wake on any interrupt.
// - Vector fetch 14 cycles after wait, plus regulator.
// - Oscillator type strap sampled during reset.
// - Strap zero selects full swing or external.
// - Monitor fails below threshold oscillator frequency.
// - Power-on flag set only by power-on.
`timescale 1ns/10ps
module scq_top #(
    parameter int QC_TIMEOUT_CYC = scq_pkg::QC_TIMEOUT_CYC,
    parameter int QC_EDGES = scq_pkg::QC_EDGES,
    parameter int VUP_CYC = scq_pkg::VUP_CYC
) (
    // Clock and power-on reset
    input wire logic clk,
    input wire logic rst_n,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins and reset sources
    input wire logic osc_in,
    input wire logic ext_rst_n,
    input wire logic low_voltage_reset_n,
    input wire logic osc_type_strap,
    input wire logic ext_irq,
    // Internal wake-up interrupt
    input wire logic int_irq,
    // System controls
    output logic sys_rst_n,
    output logic sys_clk_en,
    output logic self_clk_mode,
    output logic osc_en,
    output logic osc_lowbias_sel,
    output logic fetch_rst_vec,
    output logic fetch_irq_vec,
    output logic monitor_fail
);

    localparam int WW = $clog2(VUP_CYC + scq_pkg::WRS_CYC + 1);

    generate
        if (VUP_CYC < 1 || QC_TIMEOUT_CYC < 2 || QC_EDGES < 2)
        begin : g_bad
            $error("scq_top: parameter out of range");
        end
    endgenerate

    scq_qc_if qc ();

    scq_qual_chk #(
        .TIMEOUT_CYC(QC_TIMEOUT_CYC),
        .EDGES(QC_EDGES),
        .MON_CYC(scq_pkg::MON_FAIL_CYC)
    ) u_chk (
        .clk(clk),
        .rst_n(rst_n),
        .osc_in(osc_in),
        .qc(qc)
    );

    // Pin synchronisers: stage one feeds stage two only.
    logic [3:0] pin_s1_r, pin_s2_r;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1_r <= 4'h3;
            pin_s2_r <= 4'h3;
        end
        else
        begin
            pin_s1_r <= {ext_irq, osc_type_strap, low_voltage_reset_n, ext_rst_n};
            pin_s2_r <= pin_s1_r;
        end
    end
    wire erst_low = ~pin_s2_r[0];
    wire lvr_low = ~pin_s2_r[1];
    wire strap_s = pin_s2_r[2];
    wire eirq_s = pin_s2_r[3];

    scq_pkg::scq_state_t state_r, state_nxt;
    logic need_chk_r, need_chk_nxt;
    logic from_stop_r, from_stop_nxt;
    logic self_r, self_nxt;
    logic osc_ok_r, osc_ok_nxt;
    logic bg_r, bg_nxt;
    logic start_nxt;
    logic frst_nxt, firq_nxt;
    logic [WW-1:0] wcnt_r, wcnt_nxt;
    logic [1:0] ecnt_r;
    logic ext_hit_r;
    logic [3:0] flag_r;
    logic mode_req_v;
    scq_pkg::scq_mode_t mode_req;

    // APB decode; pready is raised by the setup cycle so every access takes no wait state.
    wire sel_ctrl = (paddr == scq_pkg::CTRL_OFS);
    wire sel_stat = (paddr == scq_pkg::STAT_OFS);
    wire sel_flag = (paddr == scq_pkg::FLAG_OFS);
    wire sel_any = sel_ctrl | sel_stat | sel_flag;
    wire setup = psel & ~penable;
    wire acc_wr = psel & penable & pwrite & pready;
    wire wr_ctrl = acc_wr & sel_ctrl & ~pslverr;
    wire wr_flag = acc_wr & sel_flag & ~pslverr;
    wire [31:0] stat_word = {23'h0, osc_ok_r, ~sys_rst_n ? 1'b0 : sys_clk_en,
        osc_lowbias_sel, qc.mon_fail, self_r, state_r};
    wire [31:0] rd_word = sel_stat ? stat_word : sel_flag ? {28'h0, flag_r} : 32'h0;
    assign mode_req = scq_pkg::scq_mode_t'(pwdata[scq_pkg::CTRL_MODE_LSB +: 2]);
    assign mode_req_v = wr_ctrl && (mode_req != scq_pkg::MODE_NONE);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup & ~sel_any;
            if (setup)
                prdata <= pwrite ? 32'h0 : rd_word;
        end
    end

    // External reset length is measured in oscillator periods, or in self clock
    // cycles when the oscillator is not known good (osc_ok_r low, as after power-on) so the pin still works.
    wire ecnt_tick = osc_ok_r ? qc.osc_edge : 1'b1;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ecnt_r <= 2'h0;
            ext_hit_r <= 1'b0;
        end
        else
        begin
            if (!erst_low)
                ecnt_r <= 2'h0;
            else if (ecnt_tick && ecnt_r != 2'(scq_pkg::MIN_RST_OSC))
                ecnt_r <= 2'(ecnt_r + 1'b1);
            ext_hit_r <= erst_low && (ecnt_r == 2'(scq_pkg::MIN_RST_OSC));
        end
    end

    wire any_irq = eirq_s | int_irq;

    always_comb
    begin
        state_nxt = state_r;
        need_chk_nxt = need_chk_r;
        from_stop_nxt = from_stop_r;
        self_nxt = self_r;
        osc_ok_nxt = osc_ok_r;
        bg_nxt = bg_r;
        start_nxt = 1'b0;
        frst_nxt = 1'b0;
        firq_nxt = 1'b0;
        wcnt_nxt = (wcnt_r == '0) ? '0 : WW'(wcnt_r - 1'b1);
        if (lvr_low)
        begin
            state_nxt = scq_pkg::ST_RESET;
            need_chk_nxt = 1'b1;
            bg_nxt = 1'b0;
        end
        else if (ext_hit_r)
        begin
            state_nxt = scq_pkg::ST_RESET;
            need_chk_nxt = need_chk_r | ~osc_ok_r;
            bg_nxt = 1'b0;
        end
        else
        begin
            unique case (state_r)
                scq_pkg::ST_RESET:
                begin
                    if (!erst_low && need_chk_r)
                    begin
                        state_nxt = scq_pkg::ST_CHECK;
                        start_nxt = 1'b1;
                        from_stop_nxt = 1'b0;
                    end
                    else if (!erst_low)
                    begin
                        state_nxt = scq_pkg::ST_RUN;
                        frst_nxt = 1'b1;
                    end
                end
                scq_pkg::ST_CHECK:
                begin
                    if (qc.pass || qc.tmo)
                    begin
                        state_nxt = scq_pkg::ST_RUN;
                        self_nxt = qc.tmo;
                        osc_ok_nxt = qc.pass;
                        need_chk_nxt = 1'b0;
                        frst_nxt = ~from_stop_r;
                        firq_nxt = from_stop_r;
                    end
                end
                scq_pkg::ST_RUN:
                begin
                    if (mode_req_v && mode_req == scq_pkg::MODE_WAIT)
                        state_nxt = scq_pkg::ST_WAIT;
                    else if (mode_req_v && mode_req == scq_pkg::MODE_PSTOP)
                        state_nxt = scq_pkg::ST_PSTOP;
                    else if (mode_req_v)
                        state_nxt = scq_pkg::ST_STOP;
                    if (qc.mon_fail && !self_r)
                    begin
                        self_nxt = 1'b1;
                        osc_ok_nxt = 1'b0;
                        bg_nxt = 1'b1;
                        start_nxt = 1'b1;
                    end
                    else if (bg_r && qc.pass)
                    begin
                        self_nxt = 1'b0;
                        osc_ok_nxt = 1'b1;
                        bg_nxt = 1'b0;
                    end
                    else if (bg_r && qc.tmo)
                        start_nxt = 1'b1;
                end
                scq_pkg::ST_WAIT:
                begin
                    if (any_irq)
                    begin
                        state_nxt = scq_pkg::ST_WRS;
                        wcnt_nxt = WW'(scq_pkg::WRS_CYC - 1);
                    end
                end
                scq_pkg::ST_PSTOP:
                begin
                    if (any_irq)
                    begin
                        state_nxt = scq_pkg::ST_VUP;
                        wcnt_nxt = WW'(VUP_CYC - 1);
                    end
                end
                scq_pkg::ST_VUP:
                begin
                    if (wcnt_r == '0)
                    begin
                        state_nxt = scq_pkg::ST_WRS;
                        wcnt_nxt = WW'(scq_pkg::WRS_CYC - 1);
                    end
                end
                scq_pkg::ST_WRS:
                begin
                    if (wcnt_r == '0)
                    begin
                        state_nxt = scq_pkg::ST_RUN;
                        firq_nxt = 1'b1;
                    end
                end
                scq_pkg::ST_STOP:
                begin
                    if (eirq_s)
                    begin
                        state_nxt = scq_pkg::ST_CHECK;
                        start_nxt = 1'b1;
                        from_stop_nxt = 1'b1;
                        bg_nxt = 1'b0;
                    end
                end
                default:
                    state_nxt = scq_pkg::ST_RESET;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= scq_pkg::ST_RESET;
            need_chk_r <= 1'b1;
            from_stop_r <= 1'b0;
            self_r <= 1'b0;
            osc_ok_r <= 1'b0;
            bg_r <= 1'b0;
            wcnt_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            need_chk_r <= need_chk_nxt;
            from_stop_r <= from_stop_nxt;
            self_r <= self_nxt;
            osc_ok_r <= osc_ok_nxt;
            bg_r <= bg_nxt;
            wcnt_r <= wcnt_nxt;
        end
    end

    assign qc.start = start_nxt;
    assign qc.mon_en = osc_ok_r && !self_r && state_r == scq_pkg::ST_RUN;

    // Registered system controls; the processor stays in reset through a reset-time check.
    wire hold_rst = (state_nxt == scq_pkg::ST_RESET) ||
        (state_nxt == scq_pkg::ST_CHECK && !from_stop_nxt);
    wire clk_run = (state_nxt == scq_pkg::ST_RUN);
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sys_rst_n <= 1'b0;
            sys_clk_en <= 1'b0;
            self_clk_mode <= 1'b0;
            osc_en <= 1'b0;
            fetch_rst_vec <= 1'b0;
            fetch_irq_vec <= 1'b0;
            monitor_fail <= 1'b0;
        end
        else
        begin
            sys_rst_n <= ~hold_rst;
            sys_clk_en <= clk_run;
            self_clk_mode <= self_nxt;
            osc_en <= (state_nxt != scq_pkg::ST_STOP);
            fetch_rst_vec <= frst_nxt;
            fetch_irq_vec <= firq_nxt;
            monitor_fail <= qc.mon_fail;
        end
    end

    // The strap is sampled while the system is held in reset, so power-on sees the pin.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            osc_lowbias_sel <= 1'b1;
        else if (!sys_rst_n)
            osc_lowbias_sel <= (strap_s != 1'b0);
    end

    // Sticky cause flags; an event in the clearing cycle wins over the clear.
    wire [3:0] flag_set = {qc.mon_fail, ext_hit_r, lvr_low, 1'b0};
    wire [3:0] flag_clr = wr_flag ? pwdata[3:0] : 4'h0;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            flag_r <= scq_pkg::FLAG_RESET;
        else
            flag_r <= (flag_r & ~flag_clr) | flag_set;
    end

endmodule

// File: scq_top_assertions.sv
// Port-level checks for the startup clock quality sequencer.
`timescale 1ns/10ps
module scq_top_assertions (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // System controls
    input wire logic sys_rst_n,
    input wire logic sys_clk_en,
    input wire logic osc_en,
    input wire logic osc_lowbias_sel,
    input wire logic fetch_rst_vec,
    input wire logic fetch_irq_vec,
    input wire logic monitor_fail
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_rst_vec_rel: assert property (fetch_rst_vec |-> sys_rst_n && sys_clk_en)
        else $error("reset vector fetch without released clocks");
    a_irq_vec_rel: assert property (fetch_irq_vec |-> sys_rst_n && sys_clk_en)
        else $error("interrupt vector fetch without released clocks");
    a_rst_vec_once: assert property (fetch_rst_vec |=> !fetch_rst_vec)
        else $error("reset vector pulse longer than one cycle");
    a_irq_vec_once: assert property (fetch_irq_vec |=> !fetch_irq_vec)
        else $error("interrupt vector pulse longer than one cycle");
    a_no_clk_rst: assert property (!sys_rst_n |-> !sys_clk_en)
        else $error("clocks released while system held in reset");
    a_stop_no_clk: assert property (!osc_en |-> !sys_clk_en)
        else $error("clocks released with oscillator stopped");
    // Eight oscillator edges cannot arrive in fewer than eight cycles.
    a_check_first: assert property ($rose(osc_en) |-> (!sys_clk_en) [*8])
        else $error("clocks released before a quality check");
    a_strap_hold: assert property (sys_rst_n && $past(sys_rst_n) |-> $stable(osc_lowbias_sel))
        else $error("oscillator type changed outside reset");
    a_apb_answer: assert property (psel && !penable |=> pready)
        else $error("no ready in first access cycle");
    a_ready_once: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");

    c_rst_vec: cover property (fetch_rst_vec);
    c_irq_vec: cover property (fetch_irq_vec);
    c_mon_fail: cover property ($rose(monitor_fail));
    c_slv_err: cover property (pslverr);
endmodule

bind scq_top scq_top_assertions i_chk (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .sys_rst_n(sys_rst_n), .sys_clk_en(sys_clk_en), .osc_en(osc_en),
    .osc_lowbias_sel(osc_lowbias_sel), .fetch_rst_vec(fetch_rst_vec),
    .fetch_irq_vec(fetch_irq_vec), .monitor_fail(monitor_fail));

// File: scq_osc_model.sv
// Behavioural crystal that swings only while enabled and healthy.
`timescale 1ns/10ps
module scq_osc_model #(
    parameter int HALF_NS = 200
) (
    // Control
    input wire logic osc_en,
    input wire logic healthy,
    // Pin
    output logic osc_in
);
    initial
    begin
        osc_in = 1'b0;
        forever
        begin
            #(HALF_NS);
            // A stopped or failed crystal rests at its bias level, it never holds a swing.
            osc_in = (osc_en && healthy) ? !osc_in : 1'b0;
        end
    end
endmodule

// File: testbench.sv
// Self-checking bench for the startup clock quality sequencer.
`timescale 1ns/10ps
module testbench;
    localparam int QC_TMO = 200;
    localparam int VUP = 100;
    localparam int WRS = scq_pkg::WRS_CYC;
    localparam int O_SRST = 0, O_CLK = 1, O_SELF = 2, O_OSC = 3;
    localparam int O_BIAS = 4, O_RV = 5, O_IV = 6, O_MON = 7;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, osc_in, ext_rst_n;
    logic low_voltage_reset_n, osc_type_strap, ext_irq, int_irq, healthy;
    logic sys_rst_n, sys_clk_en, self_clk_mode, osc_en, osc_lowbias_sel;
    logic fetch_rst_vec, fetch_irq_vec, monitor_fail;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] outs;
    int n_fail = 0;
    int tests_run = 0;
    assign outs = {monitor_fail, fetch_irq_vec, fetch_rst_vec, osc_lowbias_sel, osc_en,
        self_clk_mode, sys_clk_en, sys_rst_n};

    scq_top #(.QC_TIMEOUT_CYC(QC_TMO), .QC_EDGES(8), .VUP_CYC(VUP)) i_dut (
        .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .osc_in(osc_in), .ext_rst_n(ext_rst_n),
        .low_voltage_reset_n(low_voltage_reset_n), .osc_type_strap(osc_type_strap),
        .ext_irq(ext_irq), .int_irq(int_irq), .sys_rst_n(sys_rst_n),
        .sys_clk_en(sys_clk_en), .self_clk_mode(self_clk_mode), .osc_en(osc_en),
        .osc_lowbias_sel(osc_lowbias_sel), .fetch_rst_vec(fetch_rst_vec),
        .fetch_irq_vec(fetch_irq_vec), .monitor_fail(monitor_fail));
    scq_osc_model i_osc (.osc_en(osc_en), .healthy(healthy), .osc_in(osc_in));

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic expire();
        check(32'h0, 32'h1);
        close_out();
    endtask

    // Request is held from setup until pready is sampled high.
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int k;
        @(posedge clk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
            expire();
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(a, 1'b0, 32'h0, r, e);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, d, r, e);
    endtask

    task automatic wait_lv(input int i, input logic v, input int lim, output int n);
        n = 0;
        while (outs[i] !== v && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        if (outs[i] !== v)
            expire();
    endtask

    task automatic hold_lv(input int i, input logic v, input int cyc);
        logic bad;
        bad = 1'b0;
        repeat (cyc)
        begin
            @(posedge clk);
            bad = bad | (outs[i] !== v);
        end
        check(bad, 1'b0);
    endtask

    task automatic t_power_on();
        logic [31:0] r;
        logic e;
        int n;
        check(outs[O_CLK], 1'b0);
        wait_lv(O_RV, 1'b1, 400, n);
        check(n > 24, 1'b1);
        check({outs[O_SRST], outs[O_SELF], outs[O_BIAS]}, 3'b100);
        rd(scq_pkg::STAT_OFS, r);
        check({r[scq_pkg::STAT_RUN_BIT], r[3:0]}, 5'h12);
        rd(scq_pkg::FLAG_OFS, r);
        check(r[3:0], scq_pkg::FLAG_RESET);
        wr(scq_pkg::FLAG_OFS, 32'hf);
        rd(scq_pkg::FLAG_OFS, r);
        check(r, 32'h0);
        apb(8'h40, 1'b0, 32'h0, r, e);
        check(e, 1'b1);
        check(r, 32'h0);
        $display("test power_on done");
    endtask

    task automatic wake(input logic [1:0] m, input logic ext, input int lo, input int hi);
        int n;
        wr(scq_pkg::CTRL_OFS, {30'h0, m});
        repeat (4) @(posedge clk);
        check(outs[O_CLK], 1'b0);
        ext_irq <= ext;
        int_irq <= !ext;
        wait_lv(O_IV, 1'b1, 300, n);
        check(n >= lo && n <= hi, 1'b1);
        @(posedge clk);
        ext_irq <= 1'b0;
        int_irq <= 1'b0;
    endtask

    task automatic t_wait();
        wake(scq_pkg::MODE_WAIT, 1'b0, WRS, WRS + 5);
        $display("test wait done");
    endtask

    task automatic t_pstop();
        wake(scq_pkg::MODE_PSTOP, 1'b1, VUP + WRS, VUP + WRS + 8);
        $display("test pseudo_stop done");
    endtask
    task automatic t_stop();
        int n;
        wr(scq_pkg::CTRL_OFS, 32'h3);
        wait_lv(O_OSC, 1'b0, 10, n);
        int_irq <= 1'b1;
        hold_lv(O_IV, 1'b0, 40);
        check(outs[O_OSC], 1'b0);
        ext_irq <= 1'b1;
        wait_lv(O_IV, 1'b1, 400, n);
        check(n > 24, 1'b1);
        check(outs[O_SELF], 1'b0);
        @(posedge clk);
        ext_irq <= 1'b0;
        int_irq <= 1'b0;
        $display("test stop done");
    endtask

    task automatic t_ext_reset();
        logic [31:0] r;
        int n;
        ext_rst_n <= 1'b0;
        @(posedge clk);
        ext_rst_n <= 1'b1;
        hold_lv(O_SRST, 1'b1, 20);
        ext_rst_n <= 1'b0;
        wait_lv(O_SRST, 1'b0, 30, n);
        repeat (8) @(posedge clk);
        ext_rst_n <= 1'b1;
        // A quality check could not finish inside this bound.
        wait_lv(O_RV, 1'b1, 20, n);
        rd(scq_pkg::FLAG_OFS, r);
        check({r[scq_pkg::FLAG_EXT_BIT], r[scq_pkg::FLAG_POR_BIT]}, 2'b10);
        $display("test ext_reset done");
    endtask

    task automatic t_monitor();
        logic [31:0] r;
        int n;
        healthy <= 1'b0;
        wait_lv(O_MON, 1'b1, 130, n);
        check(n >= 90, 1'b1);
        wait_lv(O_SELF, 1'b1, 5, n);
        check(outs[O_CLK], 1'b1);
        healthy <= 1'b1;
        wait_lv(O_SELF, 1'b0, 400, n);
        check(n > 24, 1'b1);
        rd(scq_pkg::FLAG_OFS, r);
        check(r[scq_pkg::FLAG_MON_BIT], 1'b1);
        $display("test monitor done");
    endtask

    task automatic t_low_voltage();
        logic [31:0] r;
        int n;
        osc_type_strap <= 1'b1;
        healthy <= 1'b0;
        low_voltage_reset_n <= 1'b0;
        wait_lv(O_SRST, 1'b0, 10, n);
        repeat (4) @(posedge clk);
        low_voltage_reset_n <= 1'b1;
        wait_lv(O_RV, 1'b1, QC_TMO + 40, n);
        check(n >= QC_TMO, 1'b1);
        check({outs[O_SELF], outs[O_BIAS]}, 2'b11);
        rd(scq_pkg::FLAG_OFS, r);
        check({r[scq_pkg::FLAG_LVR_BIT], r[scq_pkg::FLAG_POR_BIT]}, 2'b10);
        $display("test low_voltage done");
    endtask

    initial
    begin
        clk = 1'b0;
        forever
            #50 clk = ~clk;
    end

    initial
    begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ext_rst_n = 1'b1;
        low_voltage_reset_n = 1'b1;
        osc_type_strap = 1'b0;
        ext_irq = 1'b0;
        int_irq = 1'b0;
        healthy = 1'b1;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_power_on();
        t_wait();
        t_pstop();
        t_stop();
        t_ext_reset();
        t_monitor();
        t_low_voltage();
        close_out();
    end
endmodule
